//--- common/eplk_params.svh
/*
 Constants of the partitioned EEPROM write lock: opcodes, field layout,
 reset values and timing counts. Assumes a 100 MHz system clock.
*/
// How it works
// - Array holds 512 bytes, reached only through the serial port.
// - Array accesses work in protection modes, refused while sleeping.
// - Reads wait the power-up read delay, writes the power-up write delay.
// - Array write starts only with the write latch already set.
// - Set-latch opcode sets the latch, clear-latch opcode clears it.
// - Latch clears at power-up and when a write cycle completes.
// - Lock sequence is honoured only while the write latch is set.
// - Partition code maps to one of seven locked ranges, zero locks none.
// - Lock register write starts when select rises after the lock byte.
// - Later lock bytes in one sequence overwrite earlier ones.
// - Lock setting persists until a later lock sequence replaces it.
// - Locked addresses read normally but refuse writes.
// - Opcodes 06h set latch, 04h clear latch, 01h set lock.
// - Status read returns lock byte, reserved zero; high while write busy.
// - Set-latch needs deselect after eight bits, otherwise it is ignored.
// - Addresses are 16 bits, only the low 9 are used.
`ifndef EPLK_PARAMS_SVH
`define EPLK_PARAMS_SVH

`define EPLK_OP_SET_WL 8'h06
`define EPLK_OP_CLR_WL 8'h04
`define EPLK_OP_WRITE 8'h02
`define EPLK_OP_READ 8'h03
`define EPLK_OP_STAT 8'h05
`define EPLK_OP_LOCK 8'h01

`define EPLK_ADDR_W 9
`define EPLK_PAGE_W 4
`define EPLK_LOCK_W 3
`define EPLK_PIN_RST 4'h8
`define EPLK_STAT_BUSY 8'hff

`define EPLK_CLK_MHZ 100
`define EPLK_T_PUR_US 1000
`define EPLK_T_PUW_US 5000
`define EPLK_T_NVW_US 5000
`define EPLK_PUR_CYCLES (`EPLK_T_PUR_US * `EPLK_CLK_MHZ)
`define EPLK_PUW_CYCLES (`EPLK_T_PUW_US * `EPLK_CLK_MHZ)
`define EPLK_NVW_CYCLES (`EPLK_T_NVW_US * `EPLK_CLK_MHZ)

`endif

//--- common/eplk_pkg.sv
/*
 Types of the partitioned EEPROM write lock.
 Assumes eplk_params.svh is included by the design files.
*/
package eplk_pkg;
   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000,
      ST_OPDONE = 3'b001,
      ST_ADDR = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100,
      ST_LOCK = 3'b101,
      ST_STAT = 3'b110,
      ST_SKIP = 3'b111
   } eplk_state_t;

   typedef struct packed {
      logic en;
      logic [8:0] lo;
      logic [8:0] hi;
   } eplk_range_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic sleep;
   } eplk_pins_t;
endpackage

//--- rtl/eplk_decode.sv
/*
 Decodes the partition code into the locked address range.
 Purely combinational; the caller registers whatever it needs.
*/
`timescale 1ns/100ps
module eplk_decode import eplk_pkg::*; (
   // Partition code
   input wire logic [2:0] code,
   // Locked range
   output eplk_range_t range
);
   always_comb begin
      range = '{en: 1'b1, lo: 9'h000, hi: 9'h000};
      unique case (code)
         3'h0: range = '{en: 1'b0, lo: 9'h000, hi: 9'h000};
         3'h1: range = '{en: 1'b1, lo: 9'h000, hi: 9'h07f};
         3'h2: range = '{en: 1'b1, lo: 9'h080, hi: 9'h0ff};
         3'h3: range = '{en: 1'b1, lo: 9'h100, hi: 9'h17f};
         3'h4: range = '{en: 1'b1, lo: 9'h180, hi: 9'h1ff};
         3'h5: range = '{en: 1'b1, lo: 9'h000, hi: 9'h0ff};
         3'h6: range = '{en: 1'b1, lo: 9'h000, hi: 9'h00f};
         3'h7: range = '{en: 1'b1, lo: 9'h1f0, hi: 9'h1ff};
      endcase
   end
endmodule // eplk_decode

//--- rtl/eplk_top.sv
/*
 Serial EEPROM with write latch and partition lock, driven by SPI mode 0
 pins sampled on the system clock. Assumes SCK is slow enough (under a
 sixth of CLOCK) for the three-stage pin filter.
*/
`timescale 1ns/100ps
`include "eplk_params.svh"
module eplk_top import eplk_pkg::*; #(
   parameter int PUR_CYCLES = `EPLK_PUR_CYCLES,
   parameter int PUW_CYCLES = `EPLK_PUW_CYCLES,
   parameter int NVW_CYCLES = `EPLK_NVW_CYCLES
) (
   // System
   input wire logic CLOCK,
   input wire logic ARST_N,
   // Serial port
   input wire logic SPI_CS_N,
   input wire logic SPI_SCK,
   input wire logic SPI_SI,
   output logic SPI_SO,
   output logic SPI_SO_OE,
   // Power state
   input wire logic SLEEP,
   // Status
   output logic WRITE_LATCH,
   output logic NV_BUSY
);
   localparam logic [19:0] PUR_C = 20'(PUR_CYCLES);
   localparam logic [19:0] PUW_C = 20'(PUW_CYCLES);
   localparam logic [19:0] NVW_C = 20'(NVW_CYCLES - 1);

   eplk_pins_t s1, s2, s3, pin, next_pin, pin_d;
   eplk_state_t state, next_state;
   logic [3:0] cnt, next_cnt, wptr, next_wptr;
   logic [7:0] sh_in, next_sh_in, opcode, next_opcode, out_sh, next_out_sh;
   logic [8:0] addr, next_addr;
   logic [4:0] page, next_page;
   logic [15:0] buf_vld, next_buf_vld;
   logic [2:0] lock_pend, next_lock_pend, lock_reg, next_lock_reg;
   logic lock_got, next_lock_got, so, next_so, so_oe, next_so_oe;
   logic wel, next_wel, busy, next_busy, commit_w, next_commit_w;
   logic commit_l, next_commit_l, buf_we;
   logic [19:0] busy_cnt, next_busy_cnt, pu_cnt, next_pu_cnt;
   logic [7:0] buf_q [16];
   logic [7:0] mem [512];
   logic sck_rise, sck_fall, cs_rise, pr_ok, pw_ok, any_unlocked;
   logic [7:0] byte_in;
   logic [8:0] addr_full;
   eplk_range_t rng;

   function automatic logic lock_hit(input eplk_range_t r, input logic [8:0] a);
      return r.en && (a >= r.lo) && (a <= r.hi);
   endfunction

   eplk_decode u_decode (
      .code(lock_reg),
      .range(rng)
   );

   // Pin filter: a change is taken once stages two and three agree
   assign next_pin = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & pin);

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         s1 <= `EPLK_PIN_RST;
         s2 <= `EPLK_PIN_RST;
         s3 <= `EPLK_PIN_RST;
         pin <= `EPLK_PIN_RST;
         pin_d <= `EPLK_PIN_RST;
      end else begin
         s1 <= '{cs_n: SPI_CS_N, sck: SPI_SCK, si: SPI_SI, sleep: SLEEP};
         s2 <= s1;
         s3 <= s2;
         pin <= next_pin;
         pin_d <= pin;
      end
   end

   assign sck_rise = pin.sck & ~pin_d.sck & ~pin.cs_n;
   assign sck_fall = ~pin.sck & pin_d.sck & ~pin.cs_n;
   assign cs_rise = pin.cs_n & ~pin_d.cs_n;
   assign byte_in = {sh_in[6:0], pin.si};
   assign addr_full = {addr[7:0], pin.si};
   assign pr_ok = pu_cnt >= PUR_C;
   assign pw_ok = pu_cnt >= PUW_C;
   assign buf_we = sck_rise && state == ST_WDATA && cnt[2:0] == 3'h7;

   // commit only if a byte of the page is outside the lock
   always_comb begin
      any_unlocked = 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (buf_vld[i] && !lock_hit(rng, {page, 4'(i)})) begin
            any_unlocked = 1'b1;
         end
      end
   end

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sh_in = sh_in;
      next_opcode = opcode;
      next_out_sh = out_sh;
      next_addr = addr;
      next_page = page;
      next_wptr = wptr;
      next_buf_vld = buf_vld;
      next_lock_pend = lock_pend;
      next_lock_got = lock_got;
      next_so = so;
      next_so_oe = so_oe;
      next_wel = wel;
      next_busy = busy;
      next_busy_cnt = busy_cnt;
      next_commit_w = 1'b0;
      next_commit_l = 1'b0;
      next_pu_cnt = pw_ok ? pu_cnt : pu_cnt + 20'h1;
      if (commit_w || commit_l) begin
         next_busy = 1'b1;
         next_busy_cnt = NVW_C;
      end else if (busy) begin
         if (busy_cnt == 20'h0) begin
            next_busy = 1'b0;
            // latch drops at end of write cycle
            next_wel = 1'b0;
         end else begin
            next_busy_cnt = busy_cnt - 20'h1;
         end
      end
      if (cs_rise) begin
         unique case (state)
            ST_OPDONE: begin
               // latch acts only on a clean eight-bit frame
               if (opcode == `EPLK_OP_SET_WL) begin
                  next_wel = 1'b1;
               end else if (opcode == `EPLK_OP_CLR_WL) begin
                  next_wel = 1'b0;
               end
            end
            // page commit needs a whole last byte
            ST_WDATA: next_commit_w = cnt[2:0] == 3'h0 && any_unlocked;
            // lock commit on deselect after the byte
            ST_LOCK: next_commit_l = cnt[2:0] == 3'h0 && lock_got;
            default: ;
         endcase
         next_state = ST_OPCODE;
         next_cnt = 4'h0;
         next_so_oe = 1'b0;
         next_so = 1'b0;
      end else if (pin.cs_n) begin
         next_state = ST_OPCODE;
         next_cnt = 4'h0;
      end else if (sck_rise) begin
         next_sh_in = byte_in;
         next_cnt = (state != ST_ADDR && cnt[2:0] == 3'h7) ? 4'h0 : cnt + 4'h1;
         unique case (state)
            ST_OPCODE: if (cnt[2:0] == 3'h7) begin
               next_opcode = byte_in;
               next_state = ST_SKIP;
               unique case (byte_in)
                  `EPLK_OP_SET_WL, `EPLK_OP_CLR_WL: next_state = ST_OPDONE;
                  `EPLK_OP_WRITE: if (wel && pw_ok && !busy && !pin.sleep) begin
                     next_state = ST_ADDR;
                  end
                  `EPLK_OP_READ: if (pr_ok && !busy && !pin.sleep) begin
                     next_state = ST_ADDR;
                  end
                  `EPLK_OP_LOCK: if (wel && !busy) begin
                     next_state = ST_LOCK;
                     next_lock_got = 1'b0;
                  end
                  `EPLK_OP_STAT: begin
                     next_state = ST_STAT;
                     next_so_oe = 1'b1;
                     next_out_sh = busy ? `EPLK_STAT_BUSY : {5'h0, lock_reg};
                  end
                  default: ;
               endcase
            end
            ST_OPDONE: next_state = ST_SKIP;
            ST_ADDR: begin
               // keep only the low nine address bits
               next_addr = addr_full;
               if (cnt == 4'hf) begin
                  next_cnt = 4'h0;
                  if (opcode == `EPLK_OP_READ) begin
                     next_state = ST_RDATA;
                     next_so_oe = 1'b1;
                     next_out_sh = mem[addr_full];
                     next_addr = addr_full + 9'h1;
                  end else begin
                     next_state = ST_WDATA;
                     next_page = addr_full[8:4];
                     next_wptr = addr_full[3:0];
                     next_buf_vld = 16'h0;
                  end
               end
            end
            ST_WDATA: if (buf_we) begin
               next_buf_vld[wptr] = 1'b1;
               next_wptr = wptr + 4'h1;
            end
            ST_RDATA: if (cnt[2:0] == 3'h7) begin
               next_out_sh = mem[addr];
               next_addr = addr + 9'h1;
            end
            // later bytes overwrite the pending code
            ST_LOCK: if (cnt[2:0] == 3'h7) begin
               next_lock_pend = byte_in[2:0];
               next_lock_got = 1'b1;
            end
            ST_STAT: if (cnt[2:0] == 3'h7) begin
               next_out_sh = busy ? `EPLK_STAT_BUSY : {5'h0, lock_reg};
            end
            ST_SKIP: ;
         endcase
      end else if (sck_fall && (state == ST_RDATA || state == ST_STAT)) begin
         // serial output held high while writing
         next_so = (state == ST_STAT && busy) ? 1'b1 : out_sh[7];
         next_out_sh = {out_sh[6:0], 1'b0};
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= ST_OPCODE;
         cnt <= 4'h0;
         sh_in <= 8'h00;
         opcode <= 8'h00;
         out_sh <= 8'h00;
         addr <= 9'h000;
         page <= 5'h00;
         wptr <= 4'h0;
         buf_vld <= 16'h0000;
         lock_pend <= 3'h0;
         lock_got <= 1'b0;
         so <= 1'b0;
         so_oe <= 1'b0;
         wel <= 1'b0;
         busy <= 1'b0;
         busy_cnt <= 20'h0;
         commit_w <= 1'b0;
         commit_l <= 1'b0;
         pu_cnt <= 20'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sh_in <= next_sh_in;
         opcode <= next_opcode;
         out_sh <= next_out_sh;
         addr <= next_addr;
         page <= next_page;
         wptr <= next_wptr;
         buf_vld <= next_buf_vld;
         lock_pend <= next_lock_pend;
         lock_got <= next_lock_got;
         so <= next_so;
         so_oe <= next_so_oe;
         wel <= next_wel;
         busy <= next_busy;
         busy_cnt <= next_busy_cnt;
         commit_w <= next_commit_w;
         commit_l <= next_commit_l;
         pu_cnt <= next_pu_cnt;
      end
   end

   // lock register is nonvolatile, so it has no reset
   assign next_lock_reg = commit_l ? lock_pend : lock_reg;
   always_ff @(posedge CLOCK) begin
      lock_reg <= next_lock_reg;
   end

   // byte array and page buffer; array is nonvolatile, so unreset
   genvar gi;
   for (gi = 0; gi < 512; gi++) begin : g_mem
      localparam logic [8:0] JA = 9'(gi);
      logic [7:0] next_mem;
      if (gi < 16) begin : g_buf
         logic [7:0] next_buf;
         assign next_buf = (buf_we && wptr == JA[3:0]) ? byte_in : buf_q[gi];
         always_ff @(posedge CLOCK or negedge ARST_N) begin
            if (!ARST_N) begin
               buf_q[gi] <= 8'h00;
            end else begin
               buf_q[gi] <= next_buf;
            end
         end
      end
      assign next_mem = (commit_w && page == JA[8:4] && buf_vld[JA[3:0]]
                         && !lock_hit(rng, JA)) ? buf_q[JA[3:0]] : mem[gi];
      always_ff @(posedge CLOCK) begin
         mem[gi] <= next_mem;
      end
   end

   assign SPI_SO = so;
   assign SPI_SO_OE = so_oe;
   assign WRITE_LATCH = wel;
   assign NV_BUSY = busy;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);

   wel_set_a: assert property (cs_rise && state == ST_OPDONE && opcode == `EPLK_OP_SET_WL
      |=> wel) else $error("latch not set");
   wel_frame_a: assert property (cs_rise && state == ST_SKIP && !wel && !busy
      |=> !wel) else $error("latch set by long frame");
   wel_auto_a: assert property (busy && busy_cnt == 20'h0 && !cs_rise
      |=> !wel && !busy) else $error("latch kept after write");
   write_gate_a: assert property ($rose(busy) |-> $past(wel, 2))
      else $error("write without latch");
   lock_gate_a: assert property (state == ST_LOCK |-> wel)
      else $error("lock without latch");
   lock_change_a: assert property (lock_reg != $past(lock_reg) |-> $past(commit_l))
      else $error("lock changed without commit");
   lock_commit_a: assert property (commit_l |=> lock_reg == $past(lock_pend) ##1 busy)
      else $error("lock not committed");
   // Ranges are page aligned, so a committed page must lie outside the lock
   locked_keep_a: assert property (commit_w |-> !lock_hit(rng, {page, 4'h0}))
      else $error("locked page written");
   stat_high_a: assert property (busy && state == ST_STAT && sck_fall && !cs_rise
      |=> so) else $error("status low while busy");
   read_wait_a: assert property (state == ST_RDATA |-> pr_ok && !pin.sleep)
      else $error("read too early");
   decode_map_a: assert property (lock_reg == 3'h6
      |-> rng.en && rng.lo == 9'h000 && rng.hi == 9'h00f) else $error("bad range decode");

   lock_seq_c: cover property (commit_l);
   page_write_c: cover property (commit_w && buf_vld == 16'hffff);
   stat_busy_c: cover property (state == ST_STAT && busy && sck_fall);
endmodule // eplk_top

//--- dv/eplk_host.sv
/*
 Host side of the serial port: a mode 0 master that moves whole bytes.
 Assumes CLOCK at 100 MHz; each half bit lasts ten clocks, so the pin filter
 of the device always sees a settled level.
*/
`timescale 1ns/100ps
module eplk_host import eplk_pkg::*; (
   // System
   input wire logic clock,
   // Serial port
   output logic cs_n,
   output logic sck,
   output logic si,
   input wire logic so,
   input wire logic so_oe
);
   logic active = 1'b0;
   logic oe_seen = 1'b0;
   logic [7:0] rx [6];

   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end

   // Idle data keeps moving so a stale level is never mistaken for data
   always @(posedge clock) begin
      if (!active) begin
         si <= ~si;
      end
   end

   // bytes MSB first, deselect on a byte boundary
   task automatic xfer(input logic [47:0] tx, input int n);
      logic [7:0] b;
      active = 1'b1;
      oe_seen = 1'b0;
      @(posedge clock);
      cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         for (int k = 7; k >= 0; k--) begin
            si <= tx[47];
            tx = tx << 1;
            repeat (10) @(posedge clock);
            b[k] = so;
            oe_seen = oe_seen | so_oe;
            sck <= 1'b1;
            repeat (10) @(posedge clock);
            sck <= 1'b0;
         end
         rx[i] = b;
      end
      repeat (10) @(posedge clock);
      cs_n <= 1'b1;
      repeat (10) @(posedge clock);
      active = 1'b0;
   endtask
endmodule // eplk_host

//--- dv/tb_top.sv
/*
 Self-checking bench of the partition write lock: a table of lock codes with
 a free probe address each and, for codes 1 to 7, a locked one, then hand-made edge cases.
 Assumes the host model eplk_host and shortened delay parameters.
*/
`timescale 1ns/100ps
module tb_top import eplk_pkg::*; ;
   // Long enough for the first frames after a reset to be refused
   localparam int PUR = 1100;
   localparam int PUW = 1200;
   // Long enough for a status read to land inside a write cycle
   localparam int NVW = 400;
   typedef struct packed {logic [2:0] code; logic [8:0] a; logic [8:0] b;} eplk_row_t;
   eplk_row_t rows [8] = '{
      '{3'h0, 9'h000, 9'h1ff}, '{3'h1, 9'h07f, 9'h080}, '{3'h2, 9'h080, 9'h07f},
      '{3'h3, 9'h17f, 9'h180}, '{3'h4, 9'h180, 9'h17f}, '{3'h5, 9'h0ff, 9'h100},
      '{3'h6, 9'h00f, 9'h010}, '{3'h7, 9'h1f0, 9'h1ef}};
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic sleep = 1'b0;
   logic cs_n, sck, si, so, so_oe, latch, busy;
   logic [7:0] exp_mem [512];
   int bad_count = 0;
   int num_checks = 0;

   always #5 clock = ~clock;

   eplk_host host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
   eplk_top #(.PUR_CYCLES(PUR), .PUW_CYCLES(PUW), .NVW_CYCLES(NVW)) dut (
      .CLOCK(clock), .ARST_N(arst_n), .SPI_CS_N(cs_n), .SPI_SCK(sck), .SPI_SI(si),
      .SPI_SO(so), .SPI_SO_OE(so_oe), .SLEEP(sleep), .WRITE_LATCH(latch), .NV_BUSY(busy));

   task automatic test_done();
      if (bad_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk_bit(input string what, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cmd(input logic [7:0] op);
      host.xfer({op, 40'h0}, 1);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy === 1'b1 && n < NVW + 200) begin
         @(posedge clock);
         n++;
      end
      if (busy !== 1'b0) begin
         bad_count++;
         $display("BAD busy expected 0 seen %b", busy);
         test_done();
      end
   endtask

   task automatic lock(input logic [2:0] c, input logic en);
      if (en) begin
         cmd(8'h06);
         chk_bit("latch", 1'b1, latch);
      end
      // Decoy byte first: only the last one may be committed
      host.xfer({8'h01, 5'h0, ~c, 5'h0, c, 24'h0}, 3);
      chk_bit("busy", en, busy);
      if (en) begin
         wait_idle();
      end
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic ok);
      cmd(8'h06);
      host.xfer({8'h02, 7'h0, a, d, 16'h0}, 4);
      chk_bit("busy", ok, busy);
      chk_bit("latch", 1'b1, latch);
      if (ok) begin
         exp_mem[a] = d;
         wait_idle();
         chk_bit("latch", 1'b0, latch);
      end else begin
         cmd(8'h04);
         chk_bit("latch", 1'b0, latch);
      end
   endtask

   task automatic rd(input logic [8:0] a, input int n);
      host.xfer({8'h03, 7'h0, a, 24'h0}, n);
   endtask

   task automatic stat(input logic [7:0] e);
      host.xfer({8'h05, 40'h0}, 2);
      chk_byte("status", e, host.rx[1]);
   endtask

   initial begin
      repeat (8) @(posedge clock);
      chk_bit("latch", 1'b0, latch);
      chk_bit("busy", 1'b0, busy);
      arst_n <= 1'b1;
      // host waits out the power-up delays
      repeat (PUW + PUR) @(posedge clock);
      lock(3'h0, 1'b1);
      stat(8'h00);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].a[7:0] ^ 8'h5a, 1'b1);
      end
      foreach (rows[i]) begin
         lock(rows[i].code, 1'b1);
         stat({5'h0, rows[i].code});
         wr(rows[i].a, ~exp_mem[rows[i].a], rows[i].code == 3'h0);
         wr(rows[i].b, 8'h30 + 8'(i), 1'b1);
         rd(rows[i].a, 4);
         chk_byte("locked byte", exp_mem[rows[i].a], host.rx[3]);
         rd(rows[i].b, 4);
         chk_byte("free byte", exp_mem[rows[i].b], host.rx[3]);
      end
      lock(3'h0, 1'b0);
      stat(8'h07);
      host.xfer({8'h06, 8'h02, 32'h0}, 2);
      chk_bit("latch", 1'b0, latch);
      host.xfer({8'h02, 16'h0010, 8'h11, 16'h0}, 4);
      chk_bit("busy", 1'b0, busy);
      cmd(8'h06);
      host.xfer({8'h02, 16'h0010, 8'h77, 16'h0}, 4);
      exp_mem[9'h010] = 8'h77;
      stat(8'hff);
      wait_idle();
      sleep <= 1'b1;
      wr(9'h010, 8'h22, 1'b0);
      rd(9'h010, 4);
      chk_bit("so_oe", 1'b0, host.oe_seen);
      sleep <= 1'b0;
      rd(9'h010, 4);
      chk_byte("after sleep", 8'h77, host.rx[3]);
      rd(9'h1ff, 5);
      chk_byte("wrap low", exp_mem[9'h1ff], host.rx[3]);
      chk_byte("wrap high", exp_mem[9'h000], host.rx[4]);
      arst_n <= 1'b0;
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      chk_bit("latch", 1'b0, latch);
      // Frames right after the release fall inside the power-up delays
      cmd(8'h06);
      host.xfer({8'h02, 16'h0010, 8'h55, 16'h0}, 4);
      chk_bit("busy", 1'b0, busy);
      rd(9'h010, 4);
      chk_bit("so_oe", 1'b0, host.oe_seen);
      repeat (PUW + PUR) @(posedge clock);
      stat(8'h07);
      rd(9'h010, 4);
      chk_byte("after reset", 8'h77, host.rx[3]);
      test_done();
   end
endmodule // tb_top
